// File: core/dmam_top.sv
// Data memory address modifier: system registers, transfer latch and address generation
// Behaviour
// - Register-file read copies the addressed nibble into the transfer latch.
// - Register-file write stores the transfer latch nibble at the addressed location.
// - Transfer latch is a 4-bit system register at 78H.
// - Bank select is a 4-bit system register at 79H.
// - Sixteen banks; memory instructions use the bank in bank select.
// - Addresses 74H-7FH reach one system register set from any bank.
// - Index bits 10-8 at 7AH low bits, 7-4 at 7BH, 3-0 at 7CH.
// - Index enable is bit 0 of the status word at 7FH.
// - Row pointer is 7AH low bits plus 7BH; enable is 7AH bit 3.
// - Row pointer shares the upper seven index bits physically.
// - With index enabled, operand bank and address are ORed with index.
// - Table, buffer, register-file, stack, branch and control instructions stay unmodified.
// - Row pointer enabled replaces indirect bank and row with row pointer.
// - Row pointer affects only the two indirect transfer forms.
// - Plain indirect uses operand bank and row, column from general register.
// - With indexing enabled and row pointer disabled, indirect bank and row are also ORed with index.
`default_nettype none
module dmam_top #(
   parameter int ADDR_W = 11
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Instruction request from the decoder
   input wire logic req_i,
   input wire dmam_pkg::dmam_op_type op_i,
   input wire logic [6:0] opnd_i,
   input wire logic [3:0] gr_col_i,
   input wire logic [6:0] gr_ptr_i,
   input wire logic [3:0] gr_nibble_i,
   input wire logic [6:0] rf_sel_i,
   // Addresses towards the data memory
   output logic valid_o,
   output logic [ADDR_W-1:0] mem_addr_o,
   output logic [ADDR_W-1:0] gr_addr_o,
   output logic [ADDR_W-1:0] ind_addr_o,
   output logic sys_hit_o,
   // Auxiliary register space
   input wire logic [3:0] rf_rdata_i,
   output logic [6:0] rf_addr_o,
   output logic rf_we_o,
   output logic [3:0] rf_wdata_o,
   // System register access
   input wire logic sr_wr_i,
   input wire logic sr_rd_i,
   input wire logic [6:0] sr_addr_i,
   input wire logic [3:0] sr_wdata_i,
   output logic [3:0] sr_rdata_o,
   output logic [3:0] bank_select_o
);
   // ----------------------------------------
   // System register storage
   // ----------------------------------------
   logic [3:0] xfer_latch;
   logic [3:0] bank_select;
   logic row_ptr_enable_flag;
   logic [2:0] offset_upper_bits;
   logic [3:0] offset_middle_bits;
   logic [3:0] offset_lower_bits;
   logic [3:0] program_status_word;

   // One index, the row pointer is just its upper seven bits
   wire logic [ADDR_W-1:0] offset_register;
   wire logic [6:0] row_pointer;
   wire logic offset_enable_flag;
   assign offset_register = {offset_upper_bits, offset_middle_bits, offset_lower_bits};
   assign row_pointer = offset_register[ADDR_W-1:4];
   assign offset_enable_flag = program_status_word[dmam_pkg::OFFSET_EN_BIT];

   // ----------------------------------------
   // Write decode
   // ----------------------------------------
   // Bank bits play no part here, so any bank reaches the same set
   wire logic wr_latch;
   wire logic wr_bank;
   wire logic wr_upper;
   wire logic wr_middle;
   wire logic wr_lower;
   wire logic wr_status;
   wire logic rf_read_op;
   wire logic rf_write_op;
   assign wr_latch = sr_wr_i && (sr_addr_i == dmam_pkg::SR_XFER_LATCH);
   assign wr_bank = sr_wr_i && (sr_addr_i == dmam_pkg::SR_BANK_SELECT);
   assign wr_upper = sr_wr_i && (sr_addr_i == dmam_pkg::SR_OFFSET_UPPER);
   assign wr_middle = sr_wr_i && (sr_addr_i == dmam_pkg::SR_OFFSET_MIDDLE);
   assign wr_lower = sr_wr_i && (sr_addr_i == dmam_pkg::SR_OFFSET_LOWER);
   assign wr_status = sr_wr_i && (sr_addr_i == dmam_pkg::SR_STATUS_WORD);
   assign rf_read_op = req_i && (op_i == dmam_pkg::OP_RF_READ);
   assign rf_write_op = req_i && (op_i == dmam_pkg::OP_RF_WRITE);

   // Register-file read outranks a direct write to the latch in the same cycle
   wire logic [3:0] next_latch;
   assign next_latch = rf_read_op ? rf_rdata_i : (wr_latch ? sr_wdata_i : xfer_latch);

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         xfer_latch <= dmam_pkg::NIB_RESET;
         bank_select <= dmam_pkg::NIB_RESET;
         row_ptr_enable_flag <= 1'b0;
         offset_upper_bits <= dmam_pkg::HI_RESET;
         offset_middle_bits <= dmam_pkg::NIB_RESET;
         offset_lower_bits <= dmam_pkg::NIB_RESET;
         program_status_word <= dmam_pkg::NIB_RESET;
      end else begin
         xfer_latch <= next_latch;
         if (wr_bank) begin
            bank_select <= sr_wdata_i;
         end
         if (wr_upper) begin
            row_ptr_enable_flag <= sr_wdata_i[dmam_pkg::ROW_PTR_EN_BIT];
            offset_upper_bits <= sr_wdata_i[2:0];
         end
         if (wr_middle) begin
            offset_middle_bits <= sr_wdata_i;
         end
         if (wr_lower) begin
            offset_lower_bits <= sr_wdata_i;
         end
         if (wr_status) begin
            program_status_word <= sr_wdata_i;
         end
      end
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   // Addresses this block does not own read as zero
   wire logic [3:0] sel_rdata;
   assign sel_rdata =
      (sr_addr_i == dmam_pkg::SR_XFER_LATCH) ? xfer_latch :
      (sr_addr_i == dmam_pkg::SR_BANK_SELECT) ? bank_select :
      (sr_addr_i == dmam_pkg::SR_OFFSET_UPPER) ? {row_ptr_enable_flag, offset_upper_bits} :
      (sr_addr_i == dmam_pkg::SR_OFFSET_MIDDLE) ? offset_middle_bits :
      (sr_addr_i == dmam_pkg::SR_OFFSET_LOWER) ? offset_lower_bits :
      (sr_addr_i == dmam_pkg::SR_STATUS_WORD) ? program_status_word :
      dmam_pkg::NIB_ZERO;

   // ----------------------------------------
   // Address generation
   // ----------------------------------------
   wire logic [ADDR_W-1:0] calc_mem;
   wire logic [ADDR_W-1:0] calc_gr;
   wire logic [ADDR_W-1:0] calc_ind;
   wire logic calc_sys;

   dmam_addr_calc #(
      .ADDR_W(ADDR_W)
   ) u_calc (
      .op_i(op_i),
      .bank_i(bank_select),
      .opnd_i(opnd_i),
      .gr_col_i(gr_col_i),
      .gr_ptr_i(gr_ptr_i),
      .gr_nibble_i(gr_nibble_i),
      .offset_i(offset_register),
      .offset_en_i(offset_enable_flag),
      .row_ptr_en_i(row_ptr_enable_flag),
      .mem_addr_o(calc_mem),
      .gr_addr_o(calc_gr),
      .ind_addr_o(calc_ind)
   );

   // The system set sits at the top of every bank
   assign calc_sys = (calc_mem[6:0] >= dmam_pkg::SR_FIRST);

   // Port view moves in the same edge as the register, never a cycle behind
   wire logic [3:0] next_bank_view;
   assign next_bank_view = wr_bank ? sr_wdata_i : bank_select;

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         valid_o <= 1'b0;
         mem_addr_o <= '0;
         gr_addr_o <= '0;
         ind_addr_o <= '0;
         sys_hit_o <= 1'b0;
         rf_addr_o <= '0;
         rf_we_o <= 1'b0;
         rf_wdata_o <= dmam_pkg::NIB_RESET;
         sr_rdata_o <= dmam_pkg::NIB_RESET;
         bank_select_o <= dmam_pkg::NIB_RESET;
      end else begin
         valid_o <= req_i;
         if (req_i) begin
            mem_addr_o <= calc_mem;
            gr_addr_o <= calc_gr;
            ind_addr_o <= calc_ind;
            sys_hit_o <= calc_sys;
            rf_addr_o <= rf_sel_i;
         end
         rf_we_o <= rf_write_op;
         if (rf_write_op) begin
            rf_wdata_o <= xfer_latch;
         end
         if (sr_rd_i) begin
            sr_rdata_o <= sel_rdata;
         end
         bank_select_o <= next_bank_view;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Indirect forms, shared by several checks
   function automatic logic is_ind_op(input dmam_pkg::dmam_op_type op);
      return (op == dmam_pkg::OP_IND_STORE) || (op == dmam_pkg::OP_IND_LOAD);
   endfunction

   wire logic [2:0] opnd_row;
   assign opnd_row = opnd_i[6:4];

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   chk_latch_capture: assert property (
      rf_read_op |=> xfer_latch == $past(rf_rdata_i))
      else $error("latch did not take register-file data");

   chk_rf_store: assert property (
      rf_write_op |=> rf_we_o && (rf_wdata_o == $past(xfer_latch)))
      else $error("register-file write data is not the latch");

   chk_latch_write: assert property (
      (wr_latch && !rf_read_op) |=> xfer_latch == $past(sr_wdata_i))
      else $error("latch did not take the direct write");

   chk_read_bank: assert property (
      (sr_rd_i && sr_addr_i == dmam_pkg::SR_BANK_SELECT) |=> sr_rdata_o == $past(bank_select))
      else $error("bank select read back wrong");

   chk_sys_hit: assert property (
      req_i |=> sys_hit_o == (mem_addr_o[6:0] >= dmam_pkg::SR_FIRST))
      else $error("system set hit flag wrong");

   chk_bank_write: assert property (
      wr_bank |=> (bank_select == $past(sr_wdata_i)) && (bank_select_o == $past(sr_wdata_i)))
      else $error("bank select not updated");

   chk_index_or: assert property (
      (req_i && op_i == dmam_pkg::OP_MEM && offset_enable_flag)
      |=> mem_addr_o == ({$past(bank_select), $past(opnd_i)} | $past(offset_register)))
      else $error("indexed address is not the OR");

   chk_other_plain: assert property (
      (req_i && op_i == dmam_pkg::OP_OTHER) |=> mem_addr_o == {$past(bank_select), $past(opnd_i)})
      else $error("unmodifiable instruction was modified");

   chk_rf_plain: assert property (
      (req_i && (op_i == dmam_pkg::OP_RF_READ || op_i == dmam_pkg::OP_RF_WRITE))
      |=> mem_addr_o == {$past(bank_select), $past(opnd_i)})
      else $error("register-file transfer address was modified");

   chk_row_replace: assert property (
      (req_i && (op_i == dmam_pkg::OP_IND_STORE || op_i == dmam_pkg::OP_IND_LOAD)
       && row_ptr_enable_flag)
      |=> ind_addr_o == {$past(row_pointer), $past(gr_nibble_i)})
      else $error("row pointer did not replace bank and row");

   chk_row_mem_only: assert property (
      (req_i && !is_ind_op(op_i) && row_ptr_enable_flag && !offset_enable_flag)
      |=> mem_addr_o == {$past(bank_select), $past(opnd_i)})
      else $error("row pointer changed a direct address");

   chk_index_indirect: assert property (
      (req_i && is_ind_op(op_i) && offset_enable_flag && !row_ptr_enable_flag)
      |=> ind_addr_o == ({$past(bank_select), $past(opnd_row), $past(gr_nibble_i)}
         | {$past(row_pointer), dmam_pkg::NIB_ZERO}))
      else $error("indirect bank and row not indexed");

   chk_both_enabled: assert property (
      (req_i && is_ind_op(op_i) && offset_enable_flag && row_ptr_enable_flag)
      |=> mem_addr_o == ({$past(bank_select), $past(opnd_i)} | $past(offset_register))
         && ind_addr_o == {$past(row_pointer), $past(gr_nibble_i)})
      else $error("both enables give wrong addresses");

   chk_plain_indirect: assert property (
      (req_i && is_ind_op(op_i) && !row_ptr_enable_flag && !offset_enable_flag)
      |=> ind_addr_o == {$past(bank_select), $past(opnd_row), $past(gr_nibble_i)})
      else $error("plain indirect address wrong");

   chk_gr_fixed: assert property (
      req_i |=> valid_o && (gr_addr_o == {$past(gr_ptr_i), $past(gr_col_i)}))
      else $error("general register address modified");

   chk_shared_bits: assert property (
      wr_middle |=> row_pointer[3:0] == $past(sr_wdata_i))
      else $error("row pointer does not follow index bits");

   cov_indexed_mem: cover property (req_i && op_i == dmam_pkg::OP_MEM && offset_enable_flag);
   cov_diagonal: cover property (req_i && op_i == dmam_pkg::OP_IND_STORE && row_ptr_enable_flag);
   cov_rf_round: cover property (rf_read_op ##[1:20] rf_write_op);
   cov_plain_ind: cover property (req_i && is_ind_op(op_i) && !row_ptr_enable_flag);
   cov_both_en: cover property (req_i && is_ind_op(op_i) && row_ptr_enable_flag && offset_enable_flag);
endmodule
`default_nettype wire

// File: core/dmam_pkg.sv
// Shared constants and types for the data memory address modifier
`default_nettype none
package dmam_pkg;
   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int NIB_W = 4;
   localparam int BANK_W = 4;
   localparam int ROW_W = 3;
   localparam int OPND_W = 7;
   localparam int ADDR_W = 11;
   localparam int BR_W = 7;
   localparam int IX_HI_W = 3;

   // ----------------------------------------
   // System register addresses, same in every bank
   // ----------------------------------------
   localparam logic [6:0] SR_FIRST = 7'h74;
   localparam logic [6:0] SR_XFER_LATCH = 7'h78;
   localparam logic [6:0] SR_BANK_SELECT = 7'h79;
   localparam logic [6:0] SR_OFFSET_UPPER = 7'h7a;
   localparam logic [6:0] SR_OFFSET_MIDDLE = 7'h7b;
   localparam logic [6:0] SR_OFFSET_LOWER = 7'h7c;
   localparam logic [6:0] SR_STATUS_WORD = 7'h7f;

   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int ROW_PTR_EN_BIT = 3;
   localparam int OFFSET_EN_BIT = 0;
   localparam logic [3:0] NIB_RESET = 4'h0;
   localparam logic [2:0] HI_RESET = 3'h0;
   localparam logic [3:0] NIB_ZERO = 4'h0;

   // ----------------------------------------
   // Instruction classes from the decoder
   // ----------------------------------------
   typedef enum logic [2:0] {
      OP_NONE,
      OP_MEM,
      OP_IND_STORE,
      OP_IND_LOAD,
      OP_RF_READ,
      OP_RF_WRITE,
      OP_OTHER
   } dmam_op_type;
endpackage
`default_nettype wire

// File: core/dmam_addr_calc.sv
// Combinational address generation for operand, general register and indirect target
`default_nettype none
module dmam_addr_calc #(
   parameter int ADDR_W = 11
) (
   // Instruction fields
   input wire dmam_pkg::dmam_op_type op_i,
   input wire logic [3:0] bank_i,
   input wire logic [6:0] opnd_i,
   input wire logic [3:0] gr_col_i,
   input wire logic [6:0] gr_ptr_i,
   input wire logic [3:0] gr_nibble_i,
   // Modifier state
   input wire logic [ADDR_W-1:0] offset_i,
   input wire logic offset_en_i,
   input wire logic row_ptr_en_i,
   // Results
   output logic [ADDR_W-1:0] mem_addr_o,
   output logic [ADDR_W-1:0] gr_addr_o,
   output logic [ADDR_W-1:0] ind_addr_o
);
   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire logic is_ind;
   wire logic use_offset;
   wire logic [ADDR_W-1:0] plain_addr;
   wire logic [ADDR_W-5:0] plain_br;
   wire logic [ADDR_W-5:0] ind_br;

   assign is_ind = (op_i == dmam_pkg::OP_IND_STORE) || (op_i == dmam_pkg::OP_IND_LOAD);
   // Only memory operand and the two indirect transfer instructions are modified; all others pass plain
   assign use_offset = offset_en_i && ((op_i == dmam_pkg::OP_MEM) || is_ind);
   assign plain_addr = {bank_i, opnd_i};
   assign mem_addr_o = use_offset ? (plain_addr | offset_i) : plain_addr;
   assign gr_addr_o = {gr_ptr_i, gr_col_i};
   assign plain_br = plain_addr[ADDR_W-1:4];
   // Row pointer wins over indexing for the indirect bank and row
   assign ind_br = row_ptr_en_i ? offset_i[ADDR_W-1:4] :
      (use_offset ? (plain_br | offset_i[ADDR_W-1:4]) : plain_br);
   assign ind_addr_o = {ind_br, gr_nibble_i};
endmodule
`default_nettype wire

// File: sim/dmam_aux_model.sv
// Behavioural auxiliary register space seen by the decoder and the modifier
`default_nettype none
module dmam_aux_model (
   // Clock
   input wire logic core_clk_i,
   // Read side, addressed by the decoder
   input wire logic [6:0] rd_addr_i,
   output logic [3:0] rd_data_o,
   // Write side from the modifier
   input wire logic [6:0] wr_addr_i,
   input wire logic wr_en_i,
   input wire logic [3:0] wr_data_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] mem [0:127];
   initial begin
      for (int i = 0; i < 128; i++) begin
         mem[i] = ~i[3:0];
      end
   end
   // Read is combinational: the modifier samples it with the request
   assign rd_data_o = mem[rd_addr_i];
   always @(posedge core_clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end
endmodule
`default_nettype wire

// File: sim/data_memory_address_modifier_test.sv
// Self-checking bench for the data memory address modifier
`default_nettype none
module data_memory_address_modifier_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic req_i = 1'b0;
   dmam_pkg::dmam_op_type op_i = dmam_pkg::OP_NONE;
   logic [6:0] opnd_i = 7'h00;
   logic [3:0] gr_col_i = 4'h3;
   logic [6:0] gr_ptr_i = 7'h05;
   logic [3:0] gr_nibble_i = 4'h0;
   logic [6:0] rf_sel_i = 7'h00;
   logic sr_wr_i = 1'b0;
   logic sr_rd_i = 1'b0;
   logic [6:0] sr_addr_i = 7'h00;
   logic [3:0] sr_wdata_i = 4'h0;
   logic valid_o, rf_we_o, sys_hit_o;
   logic [10:0] mem_addr_o, gr_addr_o, ind_addr_o;
   logic [3:0] rf_rdata_i, rf_wdata_o, sr_rdata_o, bank_select_o;
   logic [6:0] rf_addr_o;
   logic [6:0] regs [6] = '{7'h78, 7'h79, 7'h7a, 7'h7b, 7'h7c, 7'h7f};
   int mismatches = 0;
   int tests_run = 0;

   always #10 core_clk_i = ~core_clk_i;

   dmam_top u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(req_i), .op_i(op_i),
      .opnd_i(opnd_i), .gr_col_i(gr_col_i), .gr_ptr_i(gr_ptr_i), .gr_nibble_i(gr_nibble_i),
      .rf_sel_i(rf_sel_i), .valid_o(valid_o), .mem_addr_o(mem_addr_o), .gr_addr_o(gr_addr_o),
      .ind_addr_o(ind_addr_o), .sys_hit_o(sys_hit_o), .rf_rdata_i(rf_rdata_i),
      .rf_addr_o(rf_addr_o), .rf_we_o(rf_we_o), .rf_wdata_o(rf_wdata_o), .sr_wr_i(sr_wr_i),
      .sr_rd_i(sr_rd_i), .sr_addr_i(sr_addr_i), .sr_wdata_i(sr_wdata_i),
      .sr_rdata_o(sr_rdata_o), .bank_select_o(bank_select_o));

   dmam_aux_model u_aux (.core_clk_i(core_clk_i), .rd_addr_i(rf_sel_i), .rd_data_o(rf_rdata_i),
      .wr_addr_i(rf_addr_o), .wr_en_i(rf_we_o), .wr_data_i(rf_wdata_o));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input logic [10:0] got, input logic [10:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Idle cycle after each strobe so it is never raised twice in one step
   task automatic sr_write(input logic [6:0] a, input logic [3:0] d);
      sr_wr_i = 1'b1;
      sr_addr_i = a;
      sr_wdata_i = d;
      @(negedge core_clk_i);
      sr_wr_i = 1'b0;
      @(negedge core_clk_i);
   endtask

   task automatic sr_read(input logic [6:0] a, input logic [3:0] exp);
      sr_rd_i = 1'b1;
      sr_addr_i = a;
      @(negedge core_clk_i);
      sr_rd_i = 1'b0;
      check({7'h00, sr_rdata_o}, {7'h00, exp});
      @(negedge core_clk_i);
   endtask

   task automatic instr(input dmam_pkg::dmam_op_type op, input logic [6:0] m,
         input logic [3:0] nib, input logic [10:0] exp_mem, input logic [10:0] exp_ind,
         input logic chk_ind);
      op_i = op;
      opnd_i = m;
      gr_nibble_i = nib;
      req_i = 1'b1;
      @(negedge core_clk_i);
      req_i = 1'b0;
      check({10'h000, valid_o}, 11'h001);
      check(mem_addr_o, exp_mem);
      check(gr_addr_o, 11'h053);
      if (chk_ind) begin
         check(ind_addr_o, exp_ind);
      end
      @(negedge core_clk_i);
   endtask

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (2) @(negedge core_clk_i);
      rst_i = 1'b0;
      @(negedge core_clk_i);
      check({7'h00, bank_select_o}, 11'h000);
      for (int i = 0; i < 6; i++) begin
         sr_write(regs[i], 4'(i + 9));
      end
      for (int i = 0; i < 6; i++) begin
         sr_read(regs[i], 4'(i + 9));
      end
      sr_write(7'h74, 4'hf);
      sr_write(7'h7d, 4'hf);
      sr_read(7'h74, 4'h0);
      sr_read(7'h7d, 4'h0);
      // Index 012, enabled, bank 0
      sr_write(7'h79, 4'h0);
      sr_write(7'h7a, 4'h0);
      sr_write(7'h7b, 4'h1);
      sr_write(7'h7c, 4'h2);
      sr_write(7'h7f, 4'h1);
      instr(dmam_pkg::OP_MEM, 7'h61, 4'h0, 11'h073, 11'h000, 1'b0);
      check({10'h000, sys_hit_o}, 11'h000);
      instr(dmam_pkg::OP_OTHER, 7'h61, 4'h0, 11'h061, 11'h000, 1'b0);
      // Row pointer 6 enabled, index off
      sr_write(7'h7f, 4'h0);
      sr_write(7'h7c, 4'h0);
      sr_write(7'h7b, 4'h6);
      sr_write(7'h7a, 4'h8);
      instr(dmam_pkg::OP_IND_STORE, 7'h34, 4'h8, 11'h034, 11'h068, 1'b1);
      instr(dmam_pkg::OP_IND_LOAD, 7'h34, 4'he, 11'h034, 11'h06e, 1'b1);
      instr(dmam_pkg::OP_MEM, 7'h34, 4'h0, 11'h034, 11'h000, 1'b0);
      sr_write(7'h7a, 4'h0);
      instr(dmam_pkg::OP_IND_STORE, 7'h34, 4'h8, 11'h034, 11'h038, 1'b1);
      // Both enables, index 061
      sr_write(7'h7a, 4'h8);
      sr_write(7'h7c, 4'h1);
      sr_write(7'h7f, 4'h1);
      instr(dmam_pkg::OP_IND_STORE, 7'h34, 4'h8, 11'h075, 11'h068, 1'b1);
      check({10'h000, sys_hit_o}, 11'h001);
      // Bank 3, written again from bank 3
      sr_write(7'h79, 4'h3);
      @(negedge core_clk_i);
      check({7'h00, bank_select_o}, 11'h003);
      sr_write(7'h79, 4'h5);
      sr_read(7'h79, 4'h5);
      sr_write(7'h79, 4'h3);
      sr_write(7'h7a, 4'h4);
      sr_write(7'h7b, 4'h0);
      instr(dmam_pkg::OP_IND_STORE, 7'h34, 4'h8, 11'h5b5, 11'h5b8, 1'b1);
      // Register-file transfers stay unmodified with index on
      rf_sel_i = 7'h05;
      instr(dmam_pkg::OP_RF_READ, 7'h10, 4'h0, 11'h190, 11'h000, 1'b0);
      sr_read(7'h78, 4'ha);
      rf_sel_i = 7'h09;
      instr(dmam_pkg::OP_RF_WRITE, 7'h10, 4'h0, 11'h190, 11'h000, 1'b0);
      check({4'h0, rf_addr_o}, 11'h009);
      check({10'h000, rf_we_o}, 11'h000);
      check({7'h00, u_aux.mem[9]}, 11'h00a);
      tally_and_finish();
   end
endmodule
`default_nettype wire
